// *** tcw_pkg.sv ***
// package: constants, register map and types for the turns counter block
package tcw_pkg;
  localparam int ADDR_W = 6;
  // word indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] REG_CTRL     = 6'h1e;
  localparam logic [ADDR_W-1:0] REG_FLAGS    = 6'h26;
  localparam logic [ADDR_W-1:0] REG_CONFIG   = 6'h30;
  localparam logic [ADDR_W-1:0] REG_COUNT    = 6'h31;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 6'h32;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 6'h33;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 6'h34;
  localparam logic [ADDR_W-1:0] REG_LEVELS   = 6'h35;
  localparam logic [ADDR_W-1:0] REG_VELTHR   = 6'h36;
  localparam logic [ADDR_W-1:0] REG_SLEEPLEN = 6'h37;

  localparam logic [3:0] CMD_TURN_RESET = 4'h1;
  localparam int CMD_LSB   = 0;
  localparam int FLAG_SAT   = 0;
  localparam int FLAG_DELTA = 3;
  localparam int IRQ_SAT   = 0;
  localparam int IRQ_DELTA = 1;
  localparam int IRQ_WAKE  = 2;
  localparam int IRQ_W = 3;

  localparam int ANGLE_W = 12;
  localparam logic [ANGLE_W-1:0] ANG_180 = 12'h800;
  localparam logic [ANGLE_W-1:0] ANG_135 = 12'h600;
  localparam logic [ANGLE_W-1:0] ANG_45  = 12'h200;
  localparam int STEP45_SHIFT  = 9;
  localparam int STEP180_SHIFT = 11;

  localparam int CNT_W = 12;
  localparam logic signed [CNT_W-1:0] MAX45  = 12'sh7ff;
  localparam logic signed [CNT_W-1:0] MIN45  = 12'sh800;
  localparam logic signed [CNT_W-1:0] MAX180 = 12'sh1ff;
  localparam logic signed [CNT_W-1:0] MIN180 = 12'she00;

  localparam logic [9:0] RISE_BASE_MV = 10'd300;
  localparam logic [9:0] RISE_STEP_MV = 10'd50;
  localparam logic [9:0] FALL_FLOOR_MV = 10'd100;
  localparam logic [9:0] HYS_MV0 = 10'd50;
  localparam logic [9:0] HYS_MV1 = 10'd150;
  localparam logic [9:0] HYS_MV2 = 10'd300;
  localparam logic [9:0] HYS_MV3 = 10'd400;

  localparam int CLK_HZ = 20_000_000;
  localparam int WAKE_TIME_US = 160;
  localparam int WAKE_CYCLES = WAKE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_DIV = 64;
  localparam logic [15:0] SLEEP_UNITS_RST = 16'h0010;
  localparam logic [ANGLE_W-1:0] VELTHR_RST = 12'h100;

  typedef enum logic {MODE_STEP180, MODE_STEP45} tcw_step_type;
  typedef enum {ST_FULL, ST_WAKE, ST_SLEEP} tcw_power_type;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
  } tcw_bus_req_type;

  typedef struct packed {
    logic [2:0]   riseSel;
    logic [1:0]   hysSel;
    tcw_step_type stepSel;
    logic         lpmEnable;
  } tcw_cfg_type;
endpackage

// *** tcw_wake_levels.sv ***
// wake comparator level lookup: rise and falling levels in millivolts
`timescale 1ns/10ps
module tcw_wake_levels
  import tcw_pkg::*;
(
  input  wire logic [2:0] wake_rise_level_sel,
  input  wire logic [1:0] hysSel,
  output logic      [9:0] wake_rise_level,
  output logic      [9:0] fallLevel
);
  logic [9:0] hysMv;
  logic [9:0] rawFall;

  assign wake_rise_level = RISE_BASE_MV
    + 10'(RISE_STEP_MV * {7'h00, wake_rise_level_sel});

  always_comb begin
    unique case (hysSel)
      2'h0: hysMv = HYS_MV0;
      2'h1: hysMv = HYS_MV1;
      2'h2: hysMv = HYS_MV2;
      2'h3: hysMv = HYS_MV3;
    endcase
  end

  // subtraction may underflow, so compare before subtracting
  assign rawFall = (wake_rise_level > hysMv + FALL_FLOOR_MV) ?
                   wake_rise_level - hysMv : FALL_FLOOR_MV;
  assign fallLevel = rawFall;
endmodule

// *** tcw_turns_counter.sv ***
// turns counter with low-power duty cycle, wake input and Avalon-MM slave
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module tcw_turns_counter
  import tcw_pkg::*;
#(
  parameter int SLEEP_UNIT_CYCLES = 8192
)(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [tcw_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [tcw_pkg::ANGLE_W-1:0] sampleAngle,
  input  wire logic                      wakeIn,
  input  wire logic                      fullPower,
  output logic [11:0]                    turn_count,
  output logic [9:0]                     wake_rise_level,
  output logic [9:0]                     wakeFallLevel,
  output logic                           awake,
  output logic                           irq
);
  import tcw_pkg::*;

  tcw_bus_req_type req;
  tcw_cfg_type     cfg;
  tcw_power_type   pstate;
  logic            ack;
  logic            wr;
  logic            rd;
  logic [ANGLE_W-1:0] velThr;
  logic [15:0]     sleepUnits;
  logic            wakeMeta;
  logic            wakeSync;
  logic            wakePrev;
  logic            wakeRise;
  logic [15:0]     unitCnt;
  logic [15:0]     sleepCnt;
  logic            periodEnd;
  logic [15:0]     waitCnt;
  logic            sampleTick;
  logic            angMeta;
  logic [ANGLE_W-1:0] angSync0;
  logic [ANGLE_W-1:0] angSync1;
  logic [ANGLE_W-1:0] prevAngle;
  logic [ANGLE_W-1:0] delta;
  logic [ANGLE_W-1:0] absDelta;
  logic            deltaNeg;
  logic [ANGLE_W-1:0] accum;
  logic [ANGLE_W:0] next_accum;
  logic signed [CNT_W-1:0] stepCnt;
  logic signed [CNT_W+1:0] next_count;
  logic signed [CNT_W-1:0] countReg;
  logic signed [CNT_W-1:0] cntMax;
  logic signed [CNT_W-1:0] cntMin;
  logic            satHit;
  logic            bigDelta;
  logic            turnReset;
  logic            satFlag;
  logic            deltaFlag;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqEnable;
  logic [IRQ_W-1:0] irqEvents;
  logic [9:0]      fallMv;
  logic            sampled;
  logic [ANGLE_W-1:0] lastVel;
  logic [ANGLE_W-STEP45_SHIFT-1:0] octDiff;
  logic            halfDiff;

  assign req = '{address: avs_address, read: avs_read,
                 write: avs_write, writedata: avs_writedata};
  // one wait cycle: request answered on the second edge
  assign avs_waitrequest = (req.read | req.write) & ~ack;
  // a write lands at the edge where waitrequest is seen low
  assign wr = req.write & ack;
  // read data is registered one edge early so it stands when answered
  assign rd = req.read & ~ack;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (req.read | req.write) & ~ack;
    end
  end

  assign turnReset = wr && req.address == REG_CTRL &&
                     req.writedata[CMD_LSB +: 4] == CMD_TURN_RESET;

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg        <= '{riseSel: 3'h0, hysSel: 2'h0,
                      stepSel: MODE_STEP45, lpmEnable: 1'b0};
      velThr     <= VELTHR_RST;
      sleepUnits <= SLEEP_UNITS_RST;
    end else if (wr) begin
      unique case (req.address)
        REG_CONFIG: begin
          cfg.riseSel   <= req.writedata[2:0];
          cfg.hysSel    <= req.writedata[5:4];
          cfg.stepSel   <= tcw_step_type'(req.writedata[8]);
          cfg.lpmEnable <= req.writedata[12];
        end
        REG_VELTHR:   velThr     <= req.writedata[ANGLE_W-1:0];
        REG_SLEEPLEN: sleepUnits <= req.writedata[15:0];
        default: ;
      endcase
    end
  end

  // levels are pure lookups; the comparator itself sits off chip
  tcw_wake_levels levels (
    .wake_rise_level_sel (cfg.riseSel),
    .hysSel              (cfg.hysSel),
    .wake_rise_level     (wake_rise_level),
    .fallLevel           (fallMv)
  );
  assign wakeFallLevel = fallMv;

  // comparator output already carries hysteresis; only synchronise it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeMeta <= 1'b0;
      wakeSync <= 1'b0;
      wakePrev <= 1'b0;
    end else begin
      wakeMeta <= wakeIn;
      wakeSync <= wakeMeta;
      wakePrev <= wakeSync;
    end
  end
  assign wakeRise = wakeSync & ~wakePrev;

  // sleep period counter runs free regardless of state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unitCnt  <= '0;
      sleepCnt <= '0;
    end else if (unitCnt == 16'(SLEEP_UNIT_CYCLES - 1)) begin
      unitCnt  <= '0;
      sleepCnt <= (sleepCnt >= sleepUnits - 16'h0001) ? '0
                                                       : sleepCnt + 16'h0001;
    end else begin
      unitCnt <= unitCnt + 16'h0001;
    end
  end
  // sleep decisions fall only on these period boundaries
  assign periodEnd = unitCnt == 16'(SLEEP_UNIT_CYCLES - 1) &&
                     sleepCnt >= sleepUnits - 16'h0001;

  // sample enable: fast while held awake, once per wake window otherwise
  always_ff @(posedge clk) begin
    if (sys_rst || pstate == ST_SLEEP) begin
      waitCnt <= '0;
    end else if (sampleTick) begin
      waitCnt <= '0;
    end else begin
      waitCnt <= waitCnt + 16'h0001;
    end
  end
  // >= so a switch to the fast rate never runs past its count
  assign sampleTick = (pstate == ST_FULL || wakeSync) ?
                      waitCnt >= 16'(SAMPLE_DIV - 1) :
                      waitCnt >= 16'(WAKE_CYCLES - 1);

  // a wake visit goes to sleep only after an angle sample taken since the last sleep
  always_ff @(posedge clk) begin
    if (sys_rst || pstate == ST_SLEEP) begin
      sampled <= 1'b0;
    end else if (sampleTick && angMeta) begin
      sampled <= 1'b1;
    end
  end

  // velocity is the delta of the last sample, not the live angle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lastVel <= '0;
    end else if (sampleTick && angMeta) begin
      lastVel <= absDelta;
    end
  end

  // power state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pstate <= ST_FULL;
    end else begin
      unique case (pstate)
        ST_FULL: if (!fullPower && cfg.lpmEnable) begin
          pstate <= ST_WAKE;
        end
        ST_WAKE: if (fullPower || !cfg.lpmEnable) begin
          pstate <= ST_FULL;
        end else if (periodEnd && sampled && !wakeSync && !bigDelta &&
                     lastVel < velThr) begin
          pstate <= ST_SLEEP;
        end
        ST_SLEEP: if (fullPower || !cfg.lpmEnable) begin
          pstate <= ST_FULL;
        end else if (wakeSync || periodEnd) begin
          pstate <= ST_WAKE;
        end
      endcase
    end
  end
  assign awake = pstate != ST_SLEEP;

  // angle bus is from another domain: two stages then read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      angSync0 <= '0;
      angSync1 <= '0;
      angMeta  <= 1'b0;
    end else begin
      angSync0 <= sampleAngle;
      angSync1 <= angSync0;
      angMeta  <= 1'b1;
    end
  end

  assign delta    = angSync1 - prevAngle;
  // modular wrap: top half of the circle reads as the opposite way
  assign deltaNeg = delta >= ANG_180;
  assign absDelta = deltaNeg ? ANGLE_W'(-delta) : delta;
  assign bigDelta = sampleTick && angMeta && absDelta > ANG_135;

  // sub-step residue accumulates so slow rotation is not lost
  always_comb begin
    next_accum = {1'b0, accum} + {1'b0, delta};
    // sector differences wrap in their own width; the sign comes
    // only from the direction decision
    octDiff  = next_accum[ANGLE_W-1:STEP45_SHIFT]
               - accum[ANGLE_W-1:STEP45_SHIFT];
    halfDiff = next_accum[STEP180_SHIFT] ^ accum[STEP180_SHIFT];
    if (cfg.stepSel == MODE_STEP45) begin
      stepCnt = CNT_W'(octDiff);
      if (deltaNeg && octDiff != '0) begin
        stepCnt = stepCnt - 12'sd8;
      end
    end else begin
      stepCnt = CNT_W'(halfDiff);
      if (deltaNeg && halfDiff) begin
        stepCnt = stepCnt - 12'sd2;
      end
    end
  end

  // limits follow the step size; a mode change clamps at next sample
  always_comb begin
    if (cfg.stepSel == MODE_STEP45) begin
      cntMax = MAX45;
      cntMin = MIN45;
    end else begin
      cntMax = MAX180;
      cntMin = MIN180;
    end
  end

  assign next_count = (CNT_W+2)'(countReg) + (CNT_W+2)'(stepCnt);
  assign satHit = sampleTick && angMeta &&
                  (next_count >= (CNT_W+2)'(cntMax) && stepCnt > 0 ||
                   next_count <= (CNT_W+2)'(cntMin) && stepCnt < 0);

  // counting continues in every power state except sleep
  always_ff @(posedge clk) begin
    if (sys_rst || turnReset) begin
      countReg  <= '0;
      accum     <= '0;
      prevAngle <= angSync1;
    end else if (sampleTick && angMeta) begin
      prevAngle <= angSync1;
      accum     <= next_accum[ANGLE_W-1:0];
      if (next_count > (CNT_W+2)'(cntMax)) begin
        countReg <= cntMax;
      end else if (next_count < (CNT_W+2)'(cntMin)) begin
        countReg <= cntMin;
      end else begin
        countReg <= CNT_W'(next_count);
      end
    end
  end
  assign turn_count = countReg;

  // warning flags cleared only by the counter reset command; set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      satFlag   <= 1'b0;
      deltaFlag <= 1'b0;
    end else begin
      satFlag   <= satHit | (satFlag & ~turnReset);
      deltaFlag <= bigDelta | (deltaFlag & ~turnReset);
    end
  end

  assign irqEvents = {wakeRise, bigDelta, satHit};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEnable <= '0;
    end else if (wr && req.address == REG_IRQ_EN) begin
      irqEnable <= req.writedata[IRQ_W-1:0];
    end
  end

  // an event in the clear cycle stays set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStatus <= '0;
    end else if (wr && req.address == REG_IRQ_CLR) begin
      irqStatus <= irqEvents | (irqStatus & ~req.writedata[IRQ_W-1:0]);
    end else begin
      irqStatus <= irqEvents | irqStatus;
    end
  end
  assign irq = |(irqStatus & irqEnable);

  // unmapped reads answer zero; there is no bus error path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (rd) begin
      unique case (req.address)
        REG_FLAGS:    avs_readdata <= 32'({deltaFlag, 2'b00, satFlag});
        REG_CONFIG:   avs_readdata <= 32'({cfg.lpmEnable, 3'b000,
                                           cfg.stepSel, 2'b00, cfg.hysSel,
                                           1'b0, cfg.riseSel});
        REG_COUNT:    avs_readdata <= 32'({{20{countReg[CNT_W-1]}},
                                           countReg});
        REG_STATUS:   avs_readdata <= 32'({wakeSync, awake,
                                           pstate == ST_FULL});
        REG_IRQ_EN:   avs_readdata <= 32'(irqEnable);
        REG_IRQ_CLR:  avs_readdata <= 32'(irqStatus);
        REG_LEVELS:   avs_readdata <= 32'({6'h00, fallMv,
                                           6'h00, wake_rise_level});
        REG_VELTHR:   avs_readdata <= 32'(velThr);
        REG_SLEEPLEN: avs_readdata <= 32'(sleepUnits);
        default:      avs_readdata <= '0;
      endcase
    end
  end
endmodule

// *** tcw_turns_counter_monitor.sv ***
// assertion checker on the turns counter ports
`timescale 1ns/10ps
module tcw_turns_counter_monitor
  import tcw_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        wakeIn,
  input wire logic        fullPower,
  input wire logic [11:0] turn_count,
  input wire logic [9:0]  wake_rise_level,
  input wire logic [9:0]  wakeFallLevel,
  input wire logic        awake,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [11:0]        prevCount;
  logic signed [12:0] dCnt;
  always_ff @(posedge clk) prevCount <= turn_count;
  // a wrap would show as a jump of nearly the full range
  assign dCnt = {turn_count[11], turn_count} - {prevCount[11], prevCount};

  property p_rise_grid;
    wake_rise_level >= 10'd300 && wake_rise_level <= 10'd650 &&
    wake_rise_level % 10'd50 == 10'd0;
  endproperty
  a_rise_grid: assert property (p_rise_grid)
    else $error("rise level off grid");
  property p_fall_floor;
    wakeFallLevel >= 10'd100 && wakeFallLevel < wake_rise_level;
  endproperty
  a_fall_floor: assert property (p_fall_floor)
    else $error("fall level out of range");
  property p_hys_set;
    wakeFallLevel == 10'd100 ||
    (wake_rise_level - wakeFallLevel) inside {10'd50, 10'd150, 10'd300,
                                              10'd400};
  endproperty
  a_hys_set: assert property (p_hys_set)
    else $error("hysteresis not a listed step");
  property p_wake_exit;
    $rose(wakeIn) |-> ##[1:4] awake;
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("wake input did not wake");
  property p_wake_hold;
    wakeIn [*4] |-> awake;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("slept with wake input high");
  property p_full_awake;
    fullPower [*6] |-> awake;
  endproperty
  a_full_awake: assert property (p_full_awake)
    else $error("slept in full power");
  property p_sleep_entry;
    $fell(awake) |-> !fullPower && !$past(wakeIn, 3);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered while wake asked");
  property p_count_step;
    dCnt != 13'sd0 |-> (dCnt >= -13'sd4 && dCnt <= 13'sd4) ||
                       turn_count == 12'h000;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count jumped");
  property p_reset_clear;
    @(posedge clk) disable iff (1'b0)
      $fell(sys_rst) |-> turn_count == 12'h000 && !irq;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("count not clear after reset");
  property p_one_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus wait not one cycle");
endmodule

// *** tcw_bemf_model.sv ***
// back-emf source seen through the wake comparator
`timescale 1ns/10ps
module tcw_bemf_model (
  input  wire logic       clk,
  input  wire logic [9:0] bemfMv,
  input  wire logic [9:0] riseMv,
  input  wire logic [9:0] fallMv,
  output logic            wakeOut
);
  initial wakeOut = 1'b0;
  // between the two levels the output keeps its last state
  always @(posedge clk) begin
    if (bemfMv > riseMv) begin
      wakeOut <= 1'b1;
    end else if (bemfMv < fallMv) begin
      wakeOut <= 1'b0;
    end
  end
endmodule

// *** tcw_turns_counter_tb.sv ***
// testbench for the turns counter: bus, counting, saturation, wake
`timescale 1ns/10ps
module tcw_turns_counter_tb;
  import tcw_pkg::*;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  tcw_bus_req_type    req = '0;
  logic [31:0]        rdata;
  logic               waitReq;
  logic [ANGLE_W-1:0] sampleAngle = '0;
  logic               wakeIn;
  logic               fullPower = 1'b1;
  logic [11:0]        turnCount;
  logic [9:0]         riseLevel;
  logic [9:0]         fallLevel;
  logic               awake;
  logic               irq;
  logic [9:0]         bemfMv = '0;
  int                 failCount = 0;
  int                 nTests = 0;

  always #25 clk = ~clk;

  tcw_turns_counter #(.SLEEP_UNIT_CYCLES(8)) dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(req.address),
    .avs_read(req.read), .avs_write(req.write),
    .avs_writedata(req.writedata), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .sampleAngle(sampleAngle),
    .wakeIn(wakeIn), .fullPower(fullPower), .turn_count(turnCount),
    .wake_rise_level(riseLevel), .wakeFallLevel(fallLevel),
    .awake(awake), .irq(irq));
  tcw_bemf_model partner (.clk(clk), .bemfMv(bemfMv), .riseMv(riseLevel),
    .fallMv(fallLevel), .wakeOut(wakeIn));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic busy;
    int   n;
    busy = 1'b1;
    n = 0;
    q = '0;
    @(posedge clk);
    req <= {a, ~w, w, d};
    while (busy && n < 50) begin
      @(posedge clk);
      busy = (waitReq !== 1'b0);
      q = rdata;
      n++;
    end
    req <= {a, 1'b0, 1'b0, d};
    if (busy !== 1'b0) begin
      chk("bus answer", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(negedge clk);
  endtask
  task automatic rdchk(input string s, input logic [5:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask
  task automatic turn(input logic [11:0] d, input int cyc);
    @(posedge clk);
    sampleAngle <= sampleAngle + d;
    repeat (cyc) @(negedge clk);
  endtask
  task automatic wait_awake(input logic v, input int lim);
    int n = 0;
    while (awake !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("awake", {31'h0, v}, {31'h0, awake});
    if (awake !== v) tally_and_finish();
  endtask

  task automatic t_regs;
    rdchk("config", REG_CONFIG, 32'h100);
    rdchk("velthr", REG_VELTHR, 32'h100);
    rdchk("sleeplen", REG_SLEEPLEN, 32'h10);
    rdchk("count", REG_COUNT, 32'h0);
    rdchk("flags", REG_FLAGS, 32'h0);
    rdchk("unmapped", 6'h3f, 32'h0);
    rdchk("status", REG_STATUS, 32'h3);
    rdchk("levels", REG_LEVELS, 32'h00fa012c);
    rdchk("irq enable", REG_IRQ_EN, 32'h0);
  endtask
  task automatic t_levels;
    logic [9:0] hys [4] = '{10'd50, 10'd150, 10'd300, 10'd400};
    logic [9:0] rise;
    logic [9:0] fall;
    for (int r = 0; r < 8; r++) begin
      for (int h = 0; h < 4; h++) begin
        wr(REG_CONFIG, 32'h100 | 32'(h << 4) | 32'(r));
        rise = 10'(300 + 50 * r);
        fall = (rise >= hys[h] + 10'd100) ? rise - hys[h] : 10'd100;
        chk("rise", 32'(rise), 32'(riseLevel));
        chk("fall", 32'(fall), 32'(fallLevel));
      end
    end
  endtask
  task automatic t_count;
    wr(REG_CONFIG, 32'h100);
    wr(REG_IRQ_EN, 32'h2);
    repeat (4) turn(12'h200, 140);
    chk("count fwd", 32'h4, 32'(turnCount));
    chk("irq idle", 32'h0, 32'(irq));
    turn(12'h800, 140);
    chk("count back", 32'h0, 32'(turnCount));
    rdchk("flags delta", REG_FLAGS, 32'h8);
    chk("irq delta", 32'h1, 32'(irq));
    rdchk("irq status", REG_IRQ_CLR, 32'h2);
    wr(REG_IRQ_CLR, 32'h2);
    chk("irq clr", 32'h0, 32'(irq));
    wr(REG_CTRL, 32'h1);
    rdchk("flags rst", REG_FLAGS, 32'h0);
  endtask
  task automatic t_sat;
    wr(REG_CONFIG, 32'h0);
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 700; i++) turn(12'h5ff, 65);
    chk("count max", 32'h1ff, 32'(turnCount));
    chk("irq masked", 32'h0, 32'(irq));
    rdchk("sat status", REG_IRQ_CLR, 32'h1);
    rdchk("flags sat", REG_FLAGS, 32'h1);
    wr(REG_CTRL, 32'h1);
    turn(12'h400, 140);
    chk("count rel", 32'h0, 32'(turnCount));
    rdchk("flags clr", REG_FLAGS, 32'h0);
  endtask
  task automatic t_wake;
    logic [11:0] c0;
    wr(REG_SLEEPLEN, 32'h4);
    wr(REG_IRQ_EN, 32'h4);
    wr(REG_CONFIG, 32'h1100);
    @(posedge clk);
    fullPower <= 1'b0;
    wait_awake(1'b0, 8000);
    @(posedge clk);
    bemfMv <= 10'd400;
    wait_awake(1'b1, 8);
    repeat (2) @(negedge clk);
    chk("irq wake", 32'h1, 32'(irq));
    c0 = turnCount;
    turn(12'h200, 140);
    chk("count fast", 32'(c0 + 12'h1), 32'(turnCount));
    chk("awake held", 32'h1, 32'(awake));
    @(posedge clk);
    bemfMv <= 10'd0;
    wr(REG_IRQ_CLR, 32'h4);
    chk("irq wclr", 32'h0, 32'(irq));
    wait_awake(1'b0, 8000);
    wait_awake(1'b1, 200);
  endtask
  task automatic t_slow;
    logic [11:0] c0;
    int          n;
    n = 0;
    wr(REG_SLEEPLEN, 32'h1f4);
    c0 = turnCount;
    turn(12'h200, 2);
    while (turnCount === c0 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    chk("count slow", 32'(c0 + 12'h1), 32'(turnCount));
    chk("slow rate", 32'h1, 32'(n > SAMPLE_DIV));
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_levels();
    t_count();
    t_sat();
    t_wake();
    t_slow();
    tally_and_finish();
  end
endmodule

bind tcw_turns_counter tcw_turns_counter_monitor mon (
  .clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .wakeIn(wakeIn), .fullPower(fullPower), .turn_count(turn_count),
  .wake_rise_level(wake_rise_level), .wakeFallLevel(wakeFallLevel),
  .awake(awake), .irq(irq));
